// >>> common/smt_pkg.sv
package smt_pkg;

    // Register indices as printed (0xe3 and 0xea are not multiples of four)
    localparam logic [7:0] SMT_IDX_MON_CTRL = 8'he3;
    localparam logic [7:0] SMT_IDX_REF_TRIM = 8'hea;
    // Interrupt block and monitor state indices
    localparam logic [7:0] SMT_IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] SMT_IDX_IRQ_ENABLE = 8'hf1;
    localparam logic [7:0] SMT_IDX_IRQ_CLEAR = 8'hf2;
    localparam logic [7:0] SMT_IDX_MON_STATE = 8'hf3;

    localparam int SMT_IDX_BITS = 8;
    localparam int SMT_ADDR_BITS = 12;

    // Field positions
    localparam int SMT_TRIP_LSB = 0;
    localparam int SMT_TRIP_MSB = 2;
    localparam int SMT_PUMP_DIS_BIT = 7;
    localparam int SMT_DIV_DIS_BIT = 7;
    localparam int SMT_TEMP_LSB = 4;
    localparam int SMT_TEMP_MSB = 6;
    localparam int SMT_OFFS_LSB = 0;
    localparam int SMT_OFFS_MSB = 3;

    // Reset values and monitor write mask
    localparam logic [7:0] SMT_MON_CTRL_RST = 8'h00;
    localparam logic [7:0] SMT_MON_CTRL_WMASK = 8'h87;
    localparam logic [1:0] SMT_IRQ_EN_RST = 2'h0;

    // Interrupt status bits
    localparam int SMT_EV_LOW = 0;
    localparam int SMT_EV_RECOVER = 1;
    localparam int SMT_EV_NUM = 2;

    typedef struct packed {
        logic pumpDisable;
        logic [3:0] reserved;
        logic [2:0] tripSelect;
    } smt_mon_ctrl_t;

    typedef struct packed {
        logic dividerDisable;
        logic [2:0] temperatureTrim;
        logic [3:0] offsetTrim;
    } smt_ref_trim_t;

    // Analogue-facing controls
    typedef struct packed {
        logic [2:0] compTripSelect;
        logic [2:0] pumpTargetSelect;
        logic pumpEnable;
        smt_ref_trim_t refTrim;
    } smt_analog_ctrl_t;

endpackage : smt_pkg

// >>> src/smt_sync.sv
`timescale 1ns/10ps
`default_nettype none
module smt_sync
    import smt_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_r;

    // Stage one feeds only stage two
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stage1_r <= 1'b0;
            syncOut <= 1'b0;
        end
        else if (clkEn)
        begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule : smt_sync
`default_nettype wire

// >>> src/smt_sticky.sv
`timescale 1ns/10ps
`default_nettype none
module smt_sticky
    import smt_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic setIn,
    input wire logic clrIn,
    output logic flag_r
);
    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flag_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (setIn)
            begin
                flag_r <= 1'b1;
            end
            else if (clrIn)
            begin
                flag_r <= 1'b0;
            end
        end
    end
endmodule : smt_sticky
`default_nettype wire

// >>> src/supply_monitor_trim_control.sv
// Notes on behaviour
// - The interrupt rises while the comparator says the supply is below the chosen trip level.
// - The three low bits of the monitor control register pick one of eight comparator trip levels.
// - The same three bits drive the pump target selection.
// - Monitoring and interrupts ignore sleep and keep running.
// - Bit 7 of the monitor control register disables the pump when set; zero is the default.
// - Bits 6 to 3 of the monitor control register are reserved and the whole register resets to zero.
// - During reset the core is held off and the pump enable stays active.
// - In sleep the pump enable stays asserted unless firmware disabled it.
// - Reset loads the reference trim register with the factory five-volt value.
// - Trim bit 7 is a test-only divider disable, bits 6 to 4 temperature trim, bits 3 to 0 offset.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_trim_control
    import smt_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM_5V = 8'h48
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SMT_ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analogue side
    input wire logic sleepActive,
    input wire logic compBelowTrip,
    input wire logic irqAck,
    output logic lowVoltIrq,
    output logic coreHoldOff,
    output smt_analog_ctrl_t analogCtrl,
    // Combined interrupt
    output logic irqOut
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [SMT_IDX_BITS-1:0] regIdx;
    logic idxAligned;
    logic access;
    logic wrEn;
    logic hitMon;
    logic hitTrim;
    logic hitStat;
    logic hitEn;
    logic hitClr;
    logic hitState;
    logic mapped;

    assign regIdx = paddr[SMT_IDX_BITS+1:2];
    assign idxAligned = (paddr[1:0] == 2'h0);
    assign access = psel && penable;

    // One hit line per mapped index; a misaligned address hits nothing
    always_comb
    begin
        hitMon = 1'b0;
        hitTrim = 1'b0;
        hitStat = 1'b0;
        hitEn = 1'b0;
        hitClr = 1'b0;
        hitState = 1'b0;
        mapped = 1'b0;
        if (idxAligned)
        begin
            mapped = 1'b1;
            case (regIdx)
                SMT_IDX_MON_CTRL: hitMon = 1'b1;
                SMT_IDX_REF_TRIM: hitTrim = 1'b1;
                SMT_IDX_IRQ_STATUS: hitStat = 1'b1;
                SMT_IDX_IRQ_ENABLE: hitEn = 1'b1;
                SMT_IDX_IRQ_CLEAR: hitClr = 1'b1;
                SMT_IDX_MON_STATE: hitState = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    // Unmapped or misaligned accesses get an error response
    assign pslverr = access && !mapped;
    assign wrEn = access && pwrite && mapped && pstrb[0] && clkEn;

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    smt_mon_ctrl_t monCtrl_r;
    smt_ref_trim_t refTrim_r;
    logic trimLoaded_r;
    smt_mon_ctrl_t monCtrl_nxt;
    smt_ref_trim_t refTrim_nxt;

    // Reserved monitor bits are never stored
    always_comb
    begin
        monCtrl_nxt.pumpDisable = pwdata[SMT_PUMP_DIS_BIT];
        monCtrl_nxt.reserved = 4'h0;
        monCtrl_nxt.tripSelect = pwdata[SMT_TRIP_MSB:SMT_TRIP_LSB];
    end

    always_comb
    begin
        refTrim_nxt.dividerDisable = pwdata[SMT_DIV_DIS_BIT];
        refTrim_nxt.temperatureTrim = pwdata[SMT_TEMP_MSB:SMT_TEMP_LSB];
        refTrim_nxt.offsetTrim = pwdata[SMT_OFFS_MSB:SMT_OFFS_LSB];
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            monCtrl_r <= SMT_MON_CTRL_RST;
        end
        else if (wrEn && hitMon)
        begin
            monCtrl_r <= monCtrl_nxt;
        end
    end

    // Factory value loaded during reset; trim writes are ignored on the first clock after reset release
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            trimLoaded_r <= 1'b0;
        end
        else if (clkEn)
        begin
            trimLoaded_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            refTrim_r <= FACTORY_TRIM_5V;
        end
        else if (wrEn && hitTrim && trimLoaded_r)
        begin
            refTrim_r <= refTrim_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator and events, never gated by sleepActive

    logic compSync;
    logic compPrev_r;
    logic lowHold_r;
    logic [SMT_EV_NUM-1:0] evSet;
    logic [SMT_EV_NUM-1:0] evClr;
    logic [SMT_EV_NUM-1:0] status;
    logic [SMT_EV_NUM-1:0] irqEn_r;

    smt_sync u_comp_sync (
        .core_clk(core_clk),
        .srst(srst),
        .clkEn(clkEn),
        .asyncIn(compBelowTrip),
        .syncOut(compSync)
    );

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            compPrev_r <= 1'b0;
        end
        else if (clkEn)
        begin
            compPrev_r <= compSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Low-voltage request

    // Request holds until acknowledged; an acknowledge is ignored while the supply is still low
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            lowHold_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (compSync)
            begin
                lowHold_r <= 1'b1;
            end
            else if (irqAck)
            begin
                lowHold_r <= 1'b0;
            end
        end
    end

    assign lowVoltIrq = lowHold_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and enables

    // Entry and recovery edges of the synchronised comparator
    assign evSet[SMT_EV_LOW] = compSync && !compPrev_r;
    assign evSet[SMT_EV_RECOVER] = !compSync && compPrev_r;
    assign evClr = (wrEn && hitClr) ? pwdata[SMT_EV_NUM-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < SMT_EV_NUM; gi++)
        begin : g_ev
            smt_sticky u_sticky (
                .core_clk(core_clk),
                .srst(srst),
                .clkEn(clkEn),
                .setIn(evSet[gi]),
                .clrIn(evClr[gi]),
                .flag_r(status[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            irqEn_r <= SMT_IRQ_EN_RST;
        end
        else if (wrEn && hitEn)
        begin
            irqEn_r <= pwdata[SMT_EV_NUM-1:0];
        end
    end

    assign irqOut = |(status & irqEn_r);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data; control and trim registers are write-only and read zero

    logic [31:0] rdData_nxt;
    logic rdSetup;

    // Read data is captured in the setup cycle so it stands through the access phase
    assign rdSetup = psel && !penable && !pwrite;

    always_comb
    begin
        rdData_nxt = 32'h0000_0000;
        if (hitStat)
        begin
            rdData_nxt[SMT_EV_NUM-1:0] = status;
        end
        else if (hitEn)
        begin
            rdData_nxt[SMT_EV_NUM-1:0] = irqEn_r;
        end
        else if (hitState)
        begin
            rdData_nxt[1:0] = {sleepActive, compSync};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clkEn && rdSetup)
        begin
            prdata <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Analogue controls

    always_comb
    begin
        analogCtrl.compTripSelect = monCtrl_r.tripSelect;
        analogCtrl.pumpTargetSelect = monCtrl_r.tripSelect;
        // Pump forced on in reset; sleep does not alter it
        analogCtrl.pumpEnable = srst || !monCtrl_r.pumpDisable;
        analogCtrl.refTrim = refTrim_r;
    end

    // Core stays held off for as long as reset is applied
    assign coreHoldOff = srst;

endmodule : supply_monitor_trim_control
`default_nettype wire

// >>> tb/smt_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module smt_checker
    import smt_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM_5V = 8'h48
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SMT_ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic sleepActive,
    input wire logic compBelowTrip,
    input wire logic irqAck,
    input wire logic lowVoltIrq,
    input wire logic coreHoldOff,
    input wire smt_analog_ctrl_t analogCtrl
);
    logic wrAcc;
    logic wrMon;
    logic wrTrim;
    assign wrAcc = psel && penable && pwrite && pstrb[0] && clkEn;
    assign wrMon = wrAcc && paddr == {2'h0, SMT_IDX_MON_CTRL, 2'h0};
    assign wrTrim = wrAcc && paddr == {2'h0, SMT_IDX_REF_TRIM, 2'h0};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence sLowRun;
        (compBelowTrip && clkEn)[*3];
    endsequence
    sequence sGoodAck;
        (!compBelowTrip && clkEn)[*3] ##1 (irqAck && clkEn);
    endsequence

    a_trip_write: assert property (wrMon |=>
        analogCtrl.compTripSelect == $past(pwdata[2:0]) &&
        analogCtrl.pumpTargetSelect == $past(pwdata[2:0]))
        else $error("trip select does not follow write");
    a_pump_write: assert property (wrMon |=>
        analogCtrl.pumpEnable == !$past(pwdata[7]))
        else $error("pump enable does not follow write");
    a_trim_write: assert property (wrTrim && !$past(srst) |=>
        analogCtrl.refTrim == $past(pwdata[7:0]))
        else $error("trim does not follow write");
    a_reset_vals: assert property ($fell(srst) |-> $past(coreHoldOff) &&
        $past(analogCtrl.pumpEnable) && analogCtrl.compTripSelect == 3'h0 &&
        analogCtrl.refTrim == FACTORY_TRIM_5V)
        else $error("wrong values after reset");
    a_low_irq: assert property (sLowRun |=> lowVoltIrq)
        else $error("low supply interrupt missing");
    a_irq_hold: assert property (lowVoltIrq && !irqAck |=> lowVoltIrq)
        else $error("interrupt dropped without acknowledge");
    a_ack_clear: assert property (sGoodAck |=> !lowVoltIrq)
        else $error("interrupt not cleared by acknowledge");
    a_sleep_free: assert property ($changed(sleepActive) && !$past(wrAcc) |->
        $stable(analogCtrl))
        else $error("sleep changed analogue controls");
endmodule : smt_checker

bind supply_monitor_trim_control smt_checker #(.FACTORY_TRIM_5V(FACTORY_TRIM_5V)) uChk (
    .core_clk(core_clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .sleepActive(sleepActive), .compBelowTrip(compBelowTrip), .irqAck(irqAck),
    .lowVoltIrq(lowVoltIrq), .coreHoldOff(coreHoldOff), .analogCtrl(analogCtrl));
`default_nettype wire

// >>> tb/supply_monitor_trim_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_trim_control_tb_top
    import smt_pkg::*;
;
    localparam logic [7:0] TRIM = 8'h5a; // Arbitrary factory value
    localparam logic [11:0] MON = {2'h0, SMT_IDX_MON_CTRL, 2'h0};
    localparam logic [11:0] TRM = {2'h0, SMT_IDX_REF_TRIM, 2'h0};
    localparam logic [11:0] STA = {2'h0, SMT_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] ENA = {2'h0, SMT_IDX_IRQ_ENABLE, 2'h0};
    localparam logic [11:0] CLR = {2'h0, SMT_IDX_IRQ_CLEAR, 2'h0};
    localparam logic [11:0] STT = {2'h0, SMT_IDX_MON_STATE, 2'h0};
    logic core_clk, srst, clkEn, psel, penable, pwrite, sleepActive, compBelowTrip, irqAck;
    logic pready, pslverr, lowVoltIrq, coreHoldOff, irqOut, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    smt_analog_ctrl_t ac;
    int nMismatch = 0;
    int samplesChecked = 0;

    supply_monitor_trim_control #(.FACTORY_TRIM_5V(TRIM)) uut (.core_clk(core_clk),
        .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepActive(sleepActive), .compBelowTrip(compBelowTrip),
        .irqAck(irqAck), .lowVoltIrq(lowVoltIrq), .coreHoldOff(coreHoldOff),
        .analogCtrl(ac), .irqOut(irqOut));

    ////////////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer, then one idle cycle so psel is never driven twice per step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 20)
            nMismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task pulse_ack;
        irqAck <= 1'b1;
        @(posedge core_clk);
        irqAck <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : pulse_ack

    task complete_run;
        $display("comparisons %0d, mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (3000) @(posedge core_clk);
        nMismatch++;
        complete_run();
    end

    initial
    begin
        {srst, clkEn, pstrb} = 6'h3f;
        {psel, penable, pwrite, sleepActive, compBelowTrip, irqAck} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge core_clk);
        check("holdOff", coreHoldOff, 1'b1);
        check("pumpInReset", ac.pumpEnable, 1'b1);
        srst <= 1'b0;
        @(posedge core_clk);
        check("trimReset", ac.refTrim, TRIM);
        check("tripReset", ac.compTripSelect, 3'h0);
        check("holdOffReleased", coreHoldOff, 1'b0);
        $display("test done: reset");
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, MON, {24'h0, 5'h0f, i[2:0]});
            check("tripSelect", ac.compTripSelect, i[2:0]);
            check("pumpTarget", ac.pumpTargetSelect, i[2:0]);
            check("pumpOn", ac.pumpEnable, 1'b1);
        end
        apb(1'b0, MON, 32'h0);
        check("monRead", rd, 32'h0);
        apb(1'b1, MON, 32'h80);
        check("pumpOff", ac.pumpEnable, 1'b0);
        apb(1'b1, MON, 32'h0);
        check("pumpBack", ac.pumpEnable, 1'b1);
        clkEn <= 1'b0;
        apb(1'b1, MON, 32'h80);
        clkEn <= 1'b1;
        check("frozenPump", ac.pumpEnable, 1'b1);
        $display("test done: monitor control");
        apb(1'b1, TRM, 32'ha5);
        check("divider", ac.refTrim.dividerDisable, 1'b1);
        check("tempTrim", ac.refTrim.temperatureTrim, 3'h2);
        check("offsTrim", ac.refTrim.offsetTrim, 4'h5);
        pstrb <= 4'h0;
        apb(1'b1, TRM, 32'h3c);
        pstrb <= 4'hf;
        check("strobeOff", ac.refTrim, 8'ha5);
        apb(1'b0, 12'h100, 32'h0);
        check("slvErr", err, 1'b1);
        $display("test done: trim and bus");
        apb(1'b1, ENA, 32'h1);
        sleepActive <= 1'b1;
        compBelowTrip <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("lowIrq", lowVoltIrq, 1'b1);
        check("irqOut", irqOut, 1'b1);
        check("sleepPump", ac.pumpEnable, 1'b1);
        apb(1'b0, STT, 32'h0);
        check("monState", rd, 32'h3);
        apb(1'b1, MON, 32'h80);
        check("sleepPumpOff", ac.pumpEnable, 1'b0);
        apb(1'b1, MON, 32'h0);
        pulse_ack();
        check("heldLow", lowVoltIrq, 1'b1);
        compBelowTrip <= 1'b0;
        repeat (5) @(posedge core_clk);
        check("heldNoAck", lowVoltIrq, 1'b1);
        pulse_ack();
        check("acked", lowVoltIrq, 1'b0);
        apb(1'b0, STA, 32'h0);
        check("status", rd, 32'h3);
        apb(1'b1, ENA, 32'h0);
        check("masked", irqOut, 1'b0);
        apb(1'b1, CLR, 32'h3);
        apb(1'b0, STA, 32'h0);
        check("cleared", rd, 32'h0);
        $display("test done: interrupt");
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("holdOffAgain", coreHoldOff, 1'b1);
        srst <= 1'b0;
        @(posedge core_clk);
        check("trimAgain", ac.refTrim, TRIM);
        check("holdOffAgainOff", coreHoldOff, 1'b0);
        $display("test done: second reset");
        complete_run();
    end
endmodule : supply_monitor_trim_control_tb_top
`default_nettype wire
